// ---- verilog/hline_pkg.sv ----
// Constants for the horizontal timing block and its index/data port
// Behaviour
// - Index/data ports decode at 3BX or 3DX, chosen by misc output bit 0.
// - A 16-bit write at the index port loads index and selected register together.
// - Index is 8-bit read/write, zero at reset, also selects extension registers.
// - Data port moves 8 bits to or from the register the index selects.
// - Line length is the 9-bit total plus 5; bit 8 in overflow bit 0.
// - Active display is 9-bit display end plus 1; bit 8 in overflow bit 1.
// - Blank asserts when counter equals 9-bit blank start; bit 8 in overflow bit 2.
// - Blank ends when counter low 7 bits match the 7-bit blank end value.
// - Display skew bits 6-5 of index 03H delay display enable 0 to 3 clocks.
// - Sync asserts when counter equals 9-bit sync start; bit 8 in overflow bit 4.
// - Sync ends when counter low 6 bits match the 6-bit sync end value.
// - Sync skew bits 6-5 of the sync end register delay sync 0 to 3 clocks.
// - Sync end register bit 7 holds blank end comparison bit 5.
package hline_pkg;
	// Port addresses, mono and colour ranges
	localparam logic [15:0] MONO_INDEX_ADDR = 16'h03B4;
	localparam logic [15:0] MONO_DATA_ADDR = 16'h03B5;
	localparam logic [15:0] COLOR_INDEX_ADDR = 16'h03D4;
	localparam logic [15:0] COLOR_DATA_ADDR = 16'h03D5;
	// Register indexes
	localparam logic [7:0] IDX_LINE_LENGTH = 8'h00;
	localparam logic [7:0] IDX_ACTIVE_WIDTH = 8'h01;
	localparam logic [7:0] IDX_BLANK_BEGIN = 8'h02;
	localparam logic [7:0] IDX_BLANK_FINISH = 8'h03;
	localparam logic [7:0] IDX_SYNC_BEGIN = 8'h04;
	localparam logic [7:0] IDX_SYNC_END = 8'h05;
	localparam logic [7:0] IDX_OVERFLOW = 8'h5D;
	localparam logic [7:0] INDEX_RESET = 8'h00;
	localparam logic [7:0] TIMING_RESET = 8'h00;
	// Overflow register bit positions
	localparam int OVF_TOTAL_BIT = 0;
	localparam int OVF_DISP_BIT = 1;
	localparam int OVF_BLANK_BEGIN_BIT = 2;
	localparam int OVF_BLANK_END_BIT = 3;
	localparam int OVF_SYNC_BEGIN_BIT = 4;
	localparam int OVF_SYNC_END_BIT = 5;
	// Field positions inside registers
	localparam int SKEW_LSB = 5;
	localparam int BLANK_END_UPPER_BIT = 7;
	// Counter wraps at total plus this, giving total plus five clocks per line
	localparam logic [9:0] WRAP_EXTRA = 10'h004;
	localparam logic [1:0] SKEW_NONE = 2'h0;
endpackage : hline_pkg

// ---- verilog/skew_if.sv ----
// Carrier between the timing core and a skew delay line
interface skew_if;
	logic adv;
	logic din;
	logic [1:0] sel;
	logic dout;
	modport line (input adv, input din, input sel, output dout);
	modport user (output adv, output din, output sel, input dout);
endinterface : skew_if

// ---- verilog/skew_line.sv ----
// Delay line giving zero to three character clocks of skew
module skew_line
	import hline_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	skew_if.line port
);
	logic [2:0] tap;

	// Shift history on each character clock; output picks the tap
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			tap <= 3'h0;
			port.dout <= 1'b0;
		end
		else if (port.adv)
		begin
			tap <= {tap[1:0], port.din};
			if (port.sel == SKEW_NONE)
				port.dout <= port.din;
			else
				port.dout <= tap[port.sel - 2'h1];
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	skew_zero_a: assert property (port.adv && port.sel == 2'h0 && $stable(port.sel)
		|=> port.dout == $past(port.din)) else $error("zero skew output mismatch");
	skew_one_a: assert property (port.adv && port.sel == 2'h1
		|=> port.dout == $past(tap[0])) else $error("one clock skew output mismatch");
endmodule : skew_line

// ---- verilog/hline_timing.sv ----
// Horizontal timing generator with its index/data register port
module hline_timing
	import hline_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic char_en,
	input wire logic color_select,
	input wire logic [15:0] io_addr,
	input wire logic io_wr,
	input wire logic io_word,
	input wire logic io_rd,
	input wire logic [15:0] io_wdata,
	output logic [7:0] io_rdata,
	output logic hsync,
	output logic blank,
	output logic display_en
);
	logic [7:0] timing_index_port;
	logic [7:0] line_length_count;
	logic [7:0] active_width_count;
	logic [7:0] blank_begin_pos;
	logic [7:0] blank_finish_and_enable_delay;
	logic [7:0] sync_begin_pos;
	logic [7:0] sync_end_register;
	logic [7:0] horizontal_overflow_register;
	logic [8:0] count;
	logic [8:0] next_count;
	logic [9:0] wrap_at;
	logic [8:0] total_9;
	logic [8:0] disp_end_9;
	logic [8:0] blank_begin_9;
	logic [8:0] sync_begin_9;
	logic [6:0] blank_finish_7;
	logic [5:0] sync_end_6;
	logic sync_state;
	logic next_sync;
	logic index_hit;
	logic data_hit;
	logic [7:0] wr_sel;
	logic [7:0] wr_val;
	logic wr_en;
	logic [7:0] read_val;
	skew_if de_skew ();
	skew_if sync_skew ();

	// Port decode follows the mono/colour select
	always_comb
	begin
		if (color_select)
		begin
			index_hit = (io_addr == COLOR_INDEX_ADDR);
			data_hit = (io_addr == COLOR_DATA_ADDR);
		end
		else
		begin
			index_hit = (io_addr == MONO_INDEX_ADDR);
			data_hit = (io_addr == MONO_DATA_ADDR);
		end
	end

	// Word write at index carries register data in its high byte
	always_comb
	begin
		wr_en = 1'b0;
		wr_sel = timing_index_port;
		wr_val = io_wdata[7:0];
		if (io_wr && index_hit && io_word)
		begin
			wr_en = 1'b1;
			wr_sel = io_wdata[7:0];
			wr_val = io_wdata[15:8];
		end
		else if (io_wr && data_hit)
			wr_en = 1'b1;
	end

	// Index register, cleared by reset
	always_ff @(posedge core_clk)
	begin
		if (reset)
			timing_index_port <= INDEX_RESET;
		else if (io_wr && index_hit)
			timing_index_port <= io_wdata[7:0];
	end

	// Timing registers, cleared by reset; left at zero, blank and sync latch high after the first wrap
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			line_length_count <= TIMING_RESET;
			active_width_count <= TIMING_RESET;
			blank_begin_pos <= TIMING_RESET;
			blank_finish_and_enable_delay <= TIMING_RESET;
			sync_begin_pos <= TIMING_RESET;
			sync_end_register <= TIMING_RESET;
			horizontal_overflow_register <= TIMING_RESET;
		end
		else if (wr_en)
		begin
			if (wr_sel == IDX_LINE_LENGTH)
				line_length_count <= wr_val;
			else if (wr_sel == IDX_ACTIVE_WIDTH)
				active_width_count <= wr_val;
			else if (wr_sel == IDX_BLANK_BEGIN)
				blank_begin_pos <= wr_val;
			else if (wr_sel == IDX_BLANK_FINISH)
				blank_finish_and_enable_delay <= wr_val;
			else if (wr_sel == IDX_SYNC_BEGIN)
				sync_begin_pos <= wr_val;
			else if (wr_sel == IDX_SYNC_END)
				sync_end_register <= wr_val;
			else if (wr_sel == IDX_OVERFLOW)
				horizontal_overflow_register <= wr_val;
		end
	end

	// Read mux; unknown indexes read zero
	always_comb
	begin
		if (index_hit)
			read_val = timing_index_port;
		else if (timing_index_port == IDX_LINE_LENGTH)
			read_val = line_length_count;
		else if (timing_index_port == IDX_ACTIVE_WIDTH)
			read_val = active_width_count;
		else if (timing_index_port == IDX_BLANK_BEGIN)
			read_val = blank_begin_pos;
		else if (timing_index_port == IDX_BLANK_FINISH)
			read_val = blank_finish_and_enable_delay;
		else if (timing_index_port == IDX_SYNC_BEGIN)
			read_val = sync_begin_pos;
		else if (timing_index_port == IDX_SYNC_END)
			read_val = sync_end_register;
		else if (timing_index_port == IDX_OVERFLOW)
			read_val = horizontal_overflow_register;
		else
			read_val = 8'h00;
	end

	// Read data is captured and held until the next read that hits the index or data port
	always_ff @(posedge core_clk)
	begin
		if (reset)
			io_rdata <= 8'h00;
		else if (io_rd && (index_hit || data_hit))
			io_rdata <= read_val;
	end

	// Assemble the wide comparison values from their scattered bits
	assign total_9 = {horizontal_overflow_register[OVF_TOTAL_BIT], line_length_count};
	assign disp_end_9 = {horizontal_overflow_register[OVF_DISP_BIT], active_width_count};
	assign blank_begin_9 = {horizontal_overflow_register[OVF_BLANK_BEGIN_BIT], blank_begin_pos};
	assign sync_begin_9 = {horizontal_overflow_register[OVF_SYNC_BEGIN_BIT], sync_begin_pos};
	assign blank_finish_7 = {horizontal_overflow_register[OVF_BLANK_END_BIT],
		sync_end_register[BLANK_END_UPPER_BIT], blank_finish_and_enable_delay[4:0]};
	assign sync_end_6 = {horizontal_overflow_register[OVF_SYNC_END_BIT],
		sync_end_register[4:0]};
	assign wrap_at = {1'b0, total_9} + WRAP_EXTRA;

	// Character counter; a total near the top still wraps as 9-bit count overflows
	always_comb
	begin
		if ({1'b0, count} >= wrap_at)
			next_count = 9'h000;
		else
			next_count = count + 9'h001;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			count <= 9'h000;
		else if (char_en)
			count <= next_count;
	end

	// Blank set/clear; the start match wins if both hit
	always_ff @(posedge core_clk)
	begin
		if (reset)
			blank <= 1'b0;
		else if (char_en)
		begin
			if (next_count == blank_begin_9)
				blank <= 1'b1;
			else if (next_count[6:0] == blank_finish_7)
				blank <= 1'b0;
		end
	end

	// Sync set/clear, computed ahead so zero skew lines up with the counter
	always_comb
	begin
		next_sync = sync_state;
		if (next_count == sync_begin_9)
			next_sync = 1'b1;
		else if (next_count[5:0] == sync_end_6)
			next_sync = 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			sync_state <= 1'b0;
		else if (char_en)
			sync_state <= next_sync;
	end

	// Skew lines for display enable and sync
	assign de_skew.adv = char_en;
	assign de_skew.din = (next_count <= disp_end_9);
	assign de_skew.sel = blank_finish_and_enable_delay[SKEW_LSB +: 2];
	assign sync_skew.adv = char_en;
	assign sync_skew.din = next_sync;
	assign sync_skew.sel = sync_end_register[SKEW_LSB +: 2];

	skew_line de_line (.core_clk(core_clk), .reset(reset), .port(de_skew.line));
	skew_line sync_line (.core_clk(core_clk), .reset(reset), .port(sync_skew.line));

	assign display_en = de_skew.dout;
	assign hsync = sync_skew.dout;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	index_clear_a: assert property ($past(reset) |-> timing_index_port == 8'h00)
		else $error("index not cleared by reset");
	word_write_a: assert property (io_wr && io_word && index_hit
		&& io_wdata[7:0] == IDX_SYNC_BEGIN |=> sync_begin_pos == $past(io_wdata[15:8]))
		else $error("word write missed register");
	data_write_a: assert property (io_wr && data_hit && timing_index_port == IDX_BLANK_BEGIN
		|=> blank_begin_pos == $past(io_wdata[7:0])) else $error("data write missed");
	decode_select_a: assert property (io_wr && color_select && io_addr == MONO_INDEX_ADDR
		|=> $stable(timing_index_port)) else $error("mono port answered in colour mode");
	counter_wrap_a: assert property (char_en && {1'b0, count} == wrap_at
		|=> count == 9'h000) else $error("counter did not wrap");
	counter_step_a: assert property (char_en && {1'b0, count} < wrap_at
		|=> count == $past(count) + 9'h001) else $error("counter did not step");
	blank_start_a: assert property (char_en && next_count == blank_begin_9
		|=> blank) else $error("blank did not start");
	blank_end_a: assert property (char_en && next_count != blank_begin_9
		&& next_count[6:0] == blank_finish_7 |=> !blank) else $error("blank did not end");
	sync_start_a: assert property (char_en && next_count == sync_begin_9
		|=> sync_state) else $error("sync did not start");
	sync_end_a: assert property (char_en && next_count != sync_begin_9
		&& next_count[5:0] == sync_end_6 |=> !sync_state) else $error("sync did not end");
	active_span_a: assert property (char_en && de_skew.sel == 2'h0 && $stable(de_skew.sel)
		|=> display_en == ($past(next_count) <= $past(disp_end_9)))
		else $error("display span wrong");

	line_wrap_c: cover property (char_en && count != 9'h000 ##1 count == 9'h000);
	sync_pulse_c: cover property (!hsync ##1 hsync);
	skewed_de_c: cover property (de_skew.sel == 2'h3 && display_en);
	word_write_c: cover property (io_wr && io_word && index_hit);
endmodule : hline_timing

// ---- test/line_monitor.sv ----
// Far-side monitor model: measures sync, blank and enable spans in character clocks
module line_monitor
(
	input wire logic core_clk,
	input wire logic char_en,
	input wire logic hsync,
	input wire logic blank,
	input wire logic display_en
);
	timeunit 1ns;
	timeprecision 1ns;
	int cc, h_rise, b_rise, d_rise, lines, period, sync_w, blank_w, de_w, offset;
	bit ph, pb, pd;
	// Count character clocks as the generator sees them
	always @(posedge core_clk)
		if (char_en)
			cc <= cc + 1;
	// Sample at the falling edge so the rising-edge updates have landed
	always @(negedge core_clk)
	begin
		if (hsync && !ph)
		begin
			period = cc - h_rise;
			h_rise = cc;
			lines++;
		end
		if (!hsync && ph)
			sync_w = cc - h_rise;
		if (blank && !pb)
			b_rise = cc;
		if (!blank && pb)
			blank_w = cc - b_rise;
		if (display_en && !pd)
		begin
			d_rise = cc;
			offset = cc - h_rise;
		end
		if (!display_en && pd)
			de_w = cc - d_rise;
		ph = hsync;
		pb = blank;
		pd = display_en;
	end
endmodule : line_monitor

// ---- test/hline_timing_tb_top.sv ----
// Bench for the horizontal timing block: register port and line timing
module hline_timing_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import hline_pkg::*;
	localparam int TOTAL = 260;
	localparam int SYNC_AT = 257;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic char_en = 1'b0;
	logic color_select = 1'b1;
	logic [15:0] io_addr = 16'h0000;
	logic io_wr = 1'b0;
	logic io_word = 1'b0;
	logic io_rd = 1'b0;
	logic [15:0] io_wdata = 16'h0000;
	logic [7:0] io_rdata;
	logic hsync, blank, display_en;
	logic [31:0] lfsr = 32'h306007AA;
	int errors = 0;
	int n_checks = 0;
	logic [7:0] got;
	logic [7:0] exp_reg [7];
	logic [7:0] idx_list [7] = '{IDX_LINE_LENGTH, IDX_ACTIVE_WIDTH, IDX_BLANK_BEGIN,
		IDX_BLANK_FINISH, IDX_SYNC_BEGIN, IDX_SYNC_END, IDX_OVERFLOW};

	// Core clock, 4 ns period
	always #2 core_clk = ~core_clk;

	hline_timing hline_timing_inst (.core_clk(core_clk), .reset(reset), .char_en(char_en),
		.color_select(color_select), .io_addr(io_addr), .io_wr(io_wr), .io_word(io_word),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .hsync(hsync),
		.blank(blank), .display_en(display_en));

	line_monitor line_monitor_inst (.core_clk(core_clk), .char_en(char_en), .hsync(hsync),
		.blank(blank), .display_en(display_en));

	function automatic logic [31:0] next_rand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : next_rand

	// Hosts see a skew shift as offset change between sync and enable
	function automatic int offset_exp(input int dsk, input int ssk);
		return TOTAL + 5 - SYNC_AT - ssk + dsk;
	endfunction : offset_exp

	// Step the generator on the rising edge so readers at the falling edge never race
	always @(posedge core_clk)
		lfsr <= next_rand(lfsr);

	// Irregular character clock, about three in four cycles
	always @(negedge core_clk)
		char_en = lfsr[0] | lfsr[5];

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("BAD %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [15:0] addr, input logic [15:0] data, input logic word);
		@(negedge core_clk);
		io_addr = addr;
		io_wdata = data;
		io_word = word;
		io_wr = 1'b1;
		@(negedge core_clk);
		io_wr = 1'b0;
		io_word = 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] addr, output logic [7:0] data);
		@(negedge core_clk);
		io_addr = addr;
		io_rd = 1'b1;
		@(negedge core_clk);
		io_rd = 1'b0;
		data = io_rdata;
	endtask : rd

	// Index first, then the data port one byte up
	task automatic put(input logic [7:0] idx, input logic [7:0] val);
		wr(COLOR_INDEX_ADDR, {8'h00, idx}, 1'b0);
		wr(COLOR_DATA_ADDR, {8'h00, val}, 1'b0);
	endtask : put

	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	// Bounded wait for whole lines; a hang counts as a mismatch
	task automatic wait_lines(input int n);
		int start;
		start = line_monitor_inst.lines;
		for (int i = 0; i < 20000; i++)
		begin
			@(negedge core_clk);
			if (line_monitor_inst.lines >= start + n)
				return;
		end
		errors++;
		final_report();
	endtask : wait_lines

	// Main sequence
	initial
	begin
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		reset = 1'b0;
		rd(COLOR_INDEX_ADDR, got);
		check("index reset", got, INDEX_RESET);
		foreach (idx_list[i])
		begin
			exp_reg[i] = lfsr[23:16];
			put(idx_list[i], exp_reg[i]);
		end
		foreach (idx_list[i])
		begin
			wr(COLOR_INDEX_ADDR, {8'h00, idx_list[i]}, 1'b0);
			rd(COLOR_INDEX_ADDR, got);
			check("index", got, idx_list[i]);
			rd(COLOR_DATA_ADDR, got);
			check("data", got, exp_reg[i]);
		end
		wr(COLOR_INDEX_ADDR, 16'hA504, 1'b1);
		rd(COLOR_DATA_ADDR, got);
		check("word write", got, 8'hA5);
		// Wrong range must neither write nor refresh the read data
		wr(MONO_DATA_ADDR, 16'h005A, 1'b0);
		rd(MONO_DATA_ADDR, got);
		check("mono ignored", got, 8'hA5);
		color_select = 1'b0;
		wr(MONO_DATA_ADDR, 16'h003C, 1'b0);
		rd(COLOR_DATA_ADDR, got);
		check("color ignored", got, 8'hA5);
		rd(MONO_DATA_ADDR, got);
		check("mono data", got, 8'h3C);
		color_select = 1'b1;
		// Mono index write in colour mode must leave the index alone
		wr(MONO_INDEX_ADDR, 16'h0001, 1'b0);
		rd(COLOR_INDEX_ADDR, got);
		check("mono index ignored", got, IDX_SYNC_BEGIN);
		// Program every timing register before relying on the outputs
		put(IDX_OVERFLOW, 8'h1B);
		put(IDX_LINE_LENGTH, 8'h04);
		put(IDX_ACTIVE_WIDTH, 8'h00);
		put(IDX_BLANK_BEGIN, 8'hE0);
		put(IDX_SYNC_BEGIN, 8'h01);
		for (int s = 0; s < 4; s++)
		begin
			put(IDX_BLANK_FINISH, {1'b0, 2'(s), 5'h07});
			put(IDX_SYNC_END, {1'b1, 2'(3 - s), 5'h05});
			wait_lines(3);
			check("period", line_monitor_inst.period, TOTAL + 5);
			check("enable width", line_monitor_inst.de_w, 257);
			check("blank width", line_monitor_inst.blank_w, 7);
			check("sync width", line_monitor_inst.sync_w, 4);
			check("offset", line_monitor_inst.offset, offset_exp(s, 3 - s));
		end
		final_report();
	end
endmodule : hline_timing_tb_top
